//--- design/scf_feedback.sv
`timescale 1ns/1ns
// Overview of operation
// R1: bit 31 of the word is read (0) or write (1), and bits 25:24 pick channel one (01) or channel two (10).
// R2: after reset the feedback word reads 0x40000000 until measurement data is loaded.
// R3: with calibration select set, the 16-bit calibration current sits in bits 23:8.
// R4: with both selects clear, the 12-bit current accumulation of the last switching cycle sits in bits 23:12.
// R5: in that view bits 11:0 give the last switching period in units of 16 clocks.
// R6: in the peak and trough view bits 23:16 give the peak current, over the last dither cycle when dither is on.
// R7: with dither off the peak is the highest seen since the last read, and a read restarts it.
// R8: in the peak and trough view bits 15:8 give the trough current, over the last dither cycle when dither is on.
// R9: with dither off the trough is the lowest seen since the last read, and a read restarts it.
// R10: in the peak and trough view bits 7:0 count the switching cycles of the last dither cycle.
// R11: the switching cycle count reads zero if the channel is not operating or dither is off.
// R12: accumulation, period, peak and trough read zero if the channel is not operating.
// R13: the view follows the calibration and feedback view selects at once.
// R14: with dither on, peak and trough restart each dither cycle and latch at its end.
// R15: writing 1 to bit 23 of the autozero word starts an offset measurement on a disabled channel; 0 does nothing.
module scf_feedback
    import scf_pkg::*;
#(
    parameter int CAL_W = 16,
    parameter int ACC_W = 12,
    parameter int PER_W = 12,
    parameter int CUR_W = 8,
    parameter int SW_W  = 8
) (
    input  wire logic                    clk,                 // 100 MHz system clock
    input  wire logic                    rst,                 // async reset, active high
    input  wire logic                    fb_req,              // one-cycle feedback word request
    input  wire logic [31:0]             fb_cmd,              // request word (r/w, channel)
    input  wire logic                    az_req,              // one-cycle autozero word request
    input  wire logic [31:0]             az_cmd,              // autozero request word
    input  wire logic [NUM_CH-1:0]       cal_mode,            // calibration select per channel
    input  wire logic [NUM_CH-1:0]       feedback_view_select,// view select per channel
    input  wire logic [NUM_CH-1:0]       chan_operating,      // channel is regulating
    input  wire logic [NUM_CH-1:0]       chan_enabled,        // channel enable bit
    input  wire logic [NUM_CH-1:0]       dither_on,           // dither enabled per channel
    input  wire logic [NUM_CH-1:0]       meas_valid,          // sample valid per channel
    input  wire logic [NUM_CH*CUR_W-1:0] meas_current,        // instantaneous current
    input  wire logic [NUM_CH-1:0]       sw_end,              // switching cycle complete
    input  wire logic [NUM_CH*ACC_W-1:0] sw_accum,            // accumulation of ended cycle
    input  wire logic [NUM_CH*PER_W-1:0] sw_period,           // period of ended cycle
    input  wire logic [NUM_CH-1:0]       dither_end,          // dither cycle complete
    input  wire logic [NUM_CH*CAL_W-1:0] cal_current,         // calibration current
    output logic [31:0]                  fb_data,             // feedback word
    output logic                         fb_valid,            // word valid pulse
    output logic [NUM_CH-1:0]            autozero_trigger     // autozero start pulse
);
    logic [31:0]       fb_data_q;
    logic              fb_valid_q;
    logic [NUM_CH-1:0] az_q;

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    function automatic logic [NUM_CH-1:0] ch_dec(input logic [31:0] w);
        ch_dec = '0;
        if (w[CH_HI:CH_LO] == CH_ONE) ch_dec[0] = 1'b1; // see R1
        if (w[CH_HI:CH_LO] == CH_TWO) ch_dec[1] = 1'b1; // see R1
    endfunction : ch_dec

    wire               fb_rd  = fb_req && !fb_cmd[RW_BIT]; // see R1
    wire [NUM_CH-1:0]  fb_sel = fb_rd ? ch_dec(fb_cmd) : '0;
    wire [NUM_CH-1:0]  az_sel = (az_req && az_cmd[RW_BIT] && az_cmd[AZ_BIT]) ? ch_dec(az_cmd) : '0;

    logic [31:0] word_c [NUM_CH];

    // ----------------------------------------
    // per-channel trackers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [ACC_W-1:0] acc_q;
            logic [PER_W-1:0] per_q;
            logic [CUR_W-1:0] run_pk_q;
            logic [CUR_W-1:0] run_tr_q;
            logic [CUR_W-1:0] lat_pk_q;
            logic [CUR_W-1:0] lat_tr_q;
            logic [SW_W-1:0]  run_sw_q;
            logic [SW_W-1:0]  lat_sw_q;
            wire  [CUR_W-1:0] cur     = meas_current[g*CUR_W +: CUR_W];
            wire              op      = chan_operating[g];
            wire              dth     = dither_on[g];
            wire              smp_ok  = meas_valid[g];
            wire              sw_hit  = sw_end[g];
            wire              dth_hit = dth && dither_end[g];
            // restart on dither boundary or, dither off, on read of this channel
            wire              restart = dth ? dither_end[g] : fb_sel[g]; // see R7 R9 R14
            wire [CUR_W-1:0]  pk_n    = (smp_ok && cur > run_pk_q) ? cur : run_pk_q;
            wire [CUR_W-1:0]  tr_n    = (smp_ok && cur < run_tr_q) ? cur : run_tr_q;
            wire [CUR_W-1:0]  pk_v    = dth ? lat_pk_q : pk_n;  // see R6 R7
            wire [CUR_W-1:0]  tr_v    = dth ? lat_tr_q : tr_n;  // see R8 R9
            wire [SW_W-1:0]   sw_v    = (op && dth) ? lat_sw_q : '0; // see R11
            wire [SW_W-1:0]   sw_inc  = run_sw_q + SW_W'(sw_hit);

            // ----------------------------------------
            // last switching cycle
            // ----------------------------------------
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    acc_q <= '0;
                    per_q <= '0;
                end else if (sw_hit) begin
                    acc_q <= sw_accum[g*ACC_W +: ACC_W];  // see R4
                    per_q <= sw_period[g*PER_W +: PER_W]; // see R5
                end
            end

            // ----------------------------------------
            // running peak and trough
            // ----------------------------------------
            // a sample in the restart cycle counts toward the finished interval only
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    run_pk_q <= PK_INIT;
                    run_tr_q <= TR_INIT;
                end else if (restart) begin
                    run_pk_q <= PK_INIT; // see R14
                    run_tr_q <= TR_INIT;
                end else begin
                    run_pk_q <= pk_n;
                    run_tr_q <= tr_n;
                end
            end

            // ----------------------------------------
            // dither cycle results
            // ----------------------------------------
            // a switching cycle ending on the dither boundary still counts
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    lat_pk_q <= PK_INIT;
                    lat_tr_q <= TR_INIT;
                    lat_sw_q <= '0;
                end else if (dth_hit) begin
                    lat_pk_q <= pk_n;   // see R14
                    lat_tr_q <= tr_n;
                    lat_sw_q <= sw_inc; // see R10
                end
            end

            // held at zero with dither off, so the first dither cycle starts clean
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    run_sw_q <= '0;
                end else if (dth_hit) begin
                    run_sw_q <= '0;
                end else if (!dth) begin
                    run_sw_q <= '0;
                end else if (sw_hit) begin
                    run_sw_q <= sw_inc;
                end
            end

            // ----------------------------------------
            // view multiplexer
            // ----------------------------------------
            // combinational so a select change shows on the very next read
            wire  [CAL_W-1:0] cal_f = cal_current[g*CAL_W +: CAL_W];     // see R3
            wire  [ACC_W-1:0] acc_f = op ? acc_q : '0;                     // see R4 R12
            wire  [PER_W-1:0] per_f = op ? per_q : '0;                     // see R5 R12
            wire  [CUR_W-1:0] pk_f  = op ? pk_v : '0;                      // see R6 R12
            wire  [CUR_W-1:0] tr_f  = (op && tr_v != TR_INIT) ? tr_v : '0; // see R8 R12
            logic [31:0]      head_w;
            logic [31:0]      cal_w;
            logic [31:0]      avg_w;
            logic [31:0]      ext_w;

            always_comb begin
                head_w              = '0;
                head_w[RW_BIT]      = 1'b0;
                head_w[CH_HI:CH_LO] = fb_cmd[CH_HI:CH_LO]; // see R1
            end

            always_comb begin
                cal_w                = head_w;
                cal_w[CAL_HI:CAL_LO] = cal_f;
            end

            always_comb begin
                avg_w                = head_w;
                avg_w[ACC_HI:ACC_LO] = acc_f;
                avg_w[PER_HI:PER_LO] = per_f;
            end

            always_comb begin
                ext_w              = head_w;
                ext_w[PK_HI:PK_LO] = pk_f;
                ext_w[TR_HI:TR_LO] = tr_f;
                ext_w[SW_HI:SW_LO] = sw_v; // see R10 R11
            end

            assign word_c[g] = cal_mode[g] ? cal_w :                     // see R13
                               (feedback_view_select[g] ? ext_w : avg_w);
        end
    endgenerate

    wire [31:0] sel_word = fb_sel[0] ? word_c[0] : (fb_sel[1] ? word_c[1] : 32'h0000_0000);
    wire        load_now = |fb_sel;

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // channel 00 or 11 reads still answer, but leave the word as it was
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_valid_q <= 1'b0;
        end else begin
            fb_valid_q <= fb_rd; // see R1
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_data_q <= FB_RESET; // see R2
        end else if (load_now) begin
            fb_data_q <= sel_word;
        end
    end

    // ----------------------------------------
    // autozero start
    // ----------------------------------------
    // an enabled channel is regulating, so its offset cannot be measured
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            az_q <= '0;
        end else begin
            az_q <= az_sel & ~chan_enabled; // see R15
        end
    end

    assign fb_data          = fb_data_q;
    assign fb_valid         = fb_valid_q;
    assign autozero_trigger = az_q;
endmodule : scf_feedback

//--- pkg/scf_pkg.sv
package scf_pkg;
    // register word layout
    localparam int RW_BIT        = 31;
    localparam int CH_HI         = 25;
    localparam int CH_LO         = 24;
    localparam int AZ_BIT        = 23;
    localparam int CAL_HI        = 23;
    localparam int CAL_LO        = 8;
    localparam int ACC_HI        = 23;
    localparam int ACC_LO        = 12;
    localparam int PER_HI        = 11;
    localparam int PER_LO        = 0;
    localparam int PK_HI         = 23;
    localparam int PK_LO         = 16;
    localparam int TR_HI         = 15;
    localparam int TR_LO         = 8;
    localparam int SW_HI         = 7;
    localparam int SW_LO         = 0;
    localparam logic [31:0] FB_RESET = 32'h4000_0000;
    localparam logic [1:0]  CH_ONE   = 2'h1;
    localparam logic [1:0]  CH_TWO   = 2'h2;
    localparam int NUM_CH        = 2;
    // period lsb in system clock periods
    localparam int PERIOD_TICKS  = 16;
    localparam logic [7:0] PK_INIT = 8'h00;
    localparam logic [7:0] TR_INIT = 8'hff;
endpackage : scf_pkg

//--- test/scf_feedback_props.sv
`timescale 1ns/1ns
module scf_feedback_props
    import scf_pkg::*;
#(
    parameter int CAL_W = 16
) (
    input wire logic                    clk,                  // system clock
    input wire logic                    rst,                  // async reset, high
    input wire logic                    fb_req,               // feedback request
    input wire logic                    az_req,               // autozero request
    input wire logic                    fb_valid,             // answer strobe
    input wire logic [31:0]             fb_cmd,               // feedback word in
    input wire logic [31:0]             az_cmd,               // autozero word in
    input wire logic [31:0]             fb_data,              // feedback word out
    input wire logic [NUM_CH-1:0]       cal_mode,             // calibration select
    input wire logic [NUM_CH-1:0]       feedback_view_select, // view select
    input wire logic [NUM_CH-1:0]       chan_operating,       // channel regulating
    input wire logic [NUM_CH-1:0]       chan_enabled,         // channel enabled
    input wire logic [NUM_CH-1:0]       dither_on,            // dither enabled
    input wire logic [NUM_CH-1:0]       autozero_trigger,     // autozero pulse
    input wire logic [NUM_CH*CAL_W-1:0] cal_current           // calibration level
);
    wire rd1 = fb_req & ~fb_cmd[RW_BIT] & (fb_cmd[CH_HI:CH_LO] == CH_ONE);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    valid_after_read_a: assert property (fb_req && !fb_cmd[31] |=> fb_valid) else $error("no valid");
    valid_only_read_a: assert property (!(fb_req && !fb_cmd[31]) |=> !fb_valid) else $error("stray valid");
    chan_echo_a: assert property (rd1 |=> {fb_data[31], fb_data[25:24]} == 3'h1) else $error("bad head");
    cal_view_a: assert property (rd1 && cal_mode[0] |=> fb_data[23:8] == $past(cal_current[15:0]))
        else $error("bad cal");
    idle_zero_a: assert property (rd1 && !cal_mode[0] && !chan_operating[0] |=> fb_data[23:0] == 24'h0)
        else $error("idle nonzero");
    count_zero_a: assert property (rd1 && !cal_mode[0] && feedback_view_select[0] && !dither_on[0]
        |=> fb_data[7:0] == 8'h0) else $error("count nonzero");
    az_pulse_a: assert property (az_req && az_cmd[31] && az_cmd[23] && az_cmd[25:24] == CH_ONE && !chan_enabled[0]
        |=> autozero_trigger[0] ##1 !autozero_trigger[0]) else $error("no az pulse");
    az_quiet_a: assert property (!az_req |=> autozero_trigger == 2'h0) else $error("stray az");
    data_hold_a: assert property ($changed(fb_data) |-> fb_valid) else $error("data moved");
endmodule : scf_feedback_props
bind scf_feedback scf_feedback_props #(.CAL_W(CAL_W)) u_props (.*);

//--- test/scf_host.sv
`timescale 1ns/1ns
module scf_host (
    input  wire logic        clk,      // system clock
    input  wire logic        fb_valid, // answer strobe
    output logic             fb_req,   // feedback request
    output logic [31:0]      fb_cmd,   // feedback word
    output logic             az_req,   // autozero request
    output logic [31:0]      az_cmd    // autozero word
);
    initial {fb_req, fb_cmd, az_req, az_cmd} = '0;
    // released word is inverted so a stale value never passes
    task automatic xfer(input logic [31:0] w, output logic ok);
        @(posedge clk) #1;
        fb_req = 1'b1;
        fb_cmd = w;
        @(posedge clk) #1;
        fb_req = 1'b0;
        fb_cmd = ~w;
        ok = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (!ok) begin
                ok = (fb_valid === 1'b1);
                if (!ok) @(posedge clk) #1;
            end
        end
    endtask : xfer
    task automatic az(input logic [31:0] w);
        @(posedge clk) #1;
        az_req = 1'b1;
        az_cmd = w;
        @(posedge clk) #1;
        az_req = 1'b0;
        az_cmd = ~w;
    endtask : az
endmodule : scf_host

//--- test/solenoid_current_feedback_readback_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module solenoid_current_feedback_readback_tb;
    import scf_pkg::*;
    logic clk, rst, fb_req, az_req, fb_valid, ok;
    logic [31:0] fb_cmd, az_cmd, fb_data, cal_current;
    logic [1:0] cal_mode, feedback_view_select, chan_operating, chan_enabled, dither_on, meas_valid;
    logic [1:0] sw_end, dither_end, autozero_trigger;
    logic [15:0] meas_current;
    logic [23:0] sw_accum, sw_period;
    int miscompares = 0;
    int check_count = 0;
    scf_feedback dut (.*);
    scf_host host (.*);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic step();
        @(posedge clk) #1;
    endtask : step
    task automatic rd(input logic [23:0] e, input logic [23:0] m);
        host.xfer(32'h0100_0000, ok);
        `CHK("valid", 1'b1, ok)
        `CHK("field", e, fb_data[23:0] & m)
        if (!ok) finish_test();
    endtask : rd
    task automatic pulse(input int k);
        step();
        if (k == 0) begin
            sw_end = 2'h1;
        end else if (k == 1) begin
            dither_end = 2'h1;
        end else begin
            meas_valid = 2'h1;
        end
        step();
        {sw_end, dither_end, meas_valid} = '0;
    endtask : pulse
    task automatic smp(input logic [7:0] v);
        meas_current = {8'h0, v};
        pulse(2);
    endtask : smp
    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic t_views();
        host.xfer(32'h0, ok);
        `CHK("chan 00 valid", 1'b1, ok)
        `CHK("reset word", FB_RESET, fb_data)
        sw_accum = 24'habc;
        sw_period = 24'h123;
        pulse(0);
        rd(24'habc123, 24'hffffff);
        feedback_view_select = 2'h1;
        rd(24'h0, 24'hffffff);
        smp(8'h10);
        smp(8'h50);
        smp(8'h30);
        rd(24'h501000, 24'hffffff);
        smp(8'h20);
        rd(24'h202000, 24'hffff00);
        dither_on = 2'h1;
        pulse(1);
        pulse(0);
        pulse(0);
        pulse(0);
        smp(8'h40);
        smp(8'h60);
        pulse(1);
        rd(24'h604003, 24'hffffff);
        chan_operating = 2'h0;
        rd(24'h0, 24'hffffff);
        feedback_view_select = 2'h0;
        rd(24'h0, 24'hffffff);
        cal_mode = 2'h1;
        cal_current = 32'hbeef;
        rd(24'hbeef00, 24'hffff00);
        cal_mode = 2'h0;
        rd(24'h0, 24'hffffff);
    endtask : t_views
    task automatic t_az();
        host.az(32'h8180_0000);
        `CHK("autozero_trigger", 2'h1, autozero_trigger)
        host.az(32'h8100_0000);
        `CHK("az zero", 2'h0, autozero_trigger)
        chan_enabled = 2'h1;
        host.az(32'h8180_0000);
        `CHK("az enabled", 2'h0, autozero_trigger)
    endtask : t_az
    task automatic t_chan_two();
        chan_operating = 2'h3;
        cal_mode = 2'h0;
        feedback_view_select = 2'h0;
        sw_accum = 24'h5a6000;
        sw_period = 24'h3c4000;
        step();
        sw_end = 2'h2;
        step();
        sw_end = 2'h0;
        host.xfer(32'h0200_0000, ok);
        `CHK("two valid", 1'b1, ok)
        `CHK("two avg word", 32'h025a_63c4, fb_data)
        cal_mode = 2'h2;
        cal_current = 32'h1234_0000;
        host.xfer(32'h0200_0000, ok);
        `CHK("two cal word", 32'h0212_3400, fb_data)
        host.xfer(32'h8200_0000, ok);
        `CHK("write refused", 1'b0, ok)
        `CHK("word kept", 32'h0212_3400, fb_data)
        chan_enabled = 2'h1;
        host.az(32'h8280_0000);
        `CHK("az two", 2'h2, autozero_trigger)
    endtask : t_chan_two
    task automatic t_reset();
        step();
        rst = 1'b1;
        repeat (3) step();
        rst = 1'b0;
        host.xfer(32'h0, ok);
        `CHK("reset again", FB_RESET, fb_data)
        `CHK("az cleared", 2'h0, autozero_trigger)
    endtask : t_reset
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {cal_mode, feedback_view_select, chan_enabled, dither_on, meas_valid, sw_end, dither_end} = '0;
        {meas_current, sw_accum, sw_period, cal_current} = '0;
        chan_operating = 2'h3;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        t_views();
        t_az();
        t_chan_two();
        t_reset();
        finish_test();
    end
endmodule : solenoid_current_feedback_readback_tb
